//--- rtl/pin_mux_pkg.sv
// Shared types and constants for the decoder 1 index/home pin multiplexer
package pin_mux_pkg;

    // Function select bit positions in pin_function_select_reg
    localparam int unsigned INDEX_SPI_SEL_BIT = 0;
    localparam int unsigned HOME_SPI_SEL_BIT = 1;
    localparam int unsigned FSEL_WIDTH = 2;

    // Pull-up bits in port_c_pullup_reg
    localparam int unsigned INDEX_PULLUP_BIT = 2;
    localparam int unsigned HOME_PULLUP_BIT = 3;
    localparam int unsigned PULLUP_WIDTH = 16;

    // Pin function selection per pin
    typedef enum logic [1:0] {
        FN_DECODER,
        FN_TIMER,
        FN_SPI,
        FN_GPIO
    } pin_fn_t;

    // Three signals of a two-way pin
    typedef struct packed {
        logic o;
        logic oe;
        logic pu;
    } pad_drive_t;

    // Per-pin software configuration
    typedef struct packed {
        logic timer_sel;
        logic gpio_sel;
        logic gpio_dir_out;
        logic gpio_out;
    } pin_cfg_t;

    // Timer channel signals
    typedef struct packed {
        logic o;
        logic oe;
    } timer_chan_t;

endpackage

//--- rtl/pin_fn_decode.sv
// Function decode for one shared pin
`timescale 1ns/1ns
module pin_fn_decode
    import pin_mux_pkg::*;
(
    // Selection inputs
    input wire logic spi_sel,
    input wire logic timer_sel,
    input wire logic gpio_sel,
    input wire logic in_reset,
    // Result
    output pin_fn_t fn
);
    // SPI outranks timer, timer outranks GPIO; reset forces decoder
    always_comb begin
        if (in_reset) begin
            fn = FN_DECODER;
        end else if (spi_sel) begin
            fn = FN_SPI;
        end else if (timer_sel) begin
            fn = FN_TIMER;
        end else if (gpio_sel) begin
            fn = FN_GPIO;
        end else begin
            fn = FN_DECODER;
        end
    end
endmodule

//--- rtl/pad_sync.sv
// Two flip-flop synchroniser for pad inputs
`timescale 1ns/1ns
module pad_sync #(
    parameter int unsigned WIDTH = 2
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    // First stage is read only by the second
    // Resets to the pulled-up idle level, so no false low follows reset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= '1;
            q_r <= '1;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule

//--- rtl/decoder1_index_home_pin_mux.sv
// Pin multiplexer for decoder 1 index and home pins
//
// Functional notes
// - In decoder function the index pin feeds the decoder 1 index input.
// - In decoder function the home pin feeds the decoder 1 home input.
// - As alternate function index pin carries timer B channel 2 and home pin timer B channel 3, both ways.
// - The SPI slave output is driven only while selected and floats otherwise.
// - The slave shows each bit half a clock ahead of the master's sampling edge; here the pad register changes on the rising mclk edge, a full clock ahead.
// - Index pin takes the SPI slave output function only when index_pin_spi_select is set.
// - Home pin takes the SPI select function only when home_pin_spi_select is set.
// - As SPI master the select input serves multi-master arbitration.
// - As SPI slave the select input selects this device, which answers only while selected.
// - Port C bits 2 and 3 are each set as input or output by software.
// - On the full variant the index pin is the decoder index after reset.
// - On the full variant the home pin is the decoder home after reset.
// - Clearing pull-up bit 2 disables the index pin pull-up.
// - Clearing pull-up bit 3 disables the home pin pull-up.
`timescale 1ns/1ns
module decoder1_index_home_pin_mux
    import pin_mux_pkg::*;
#(
    parameter bit FULL_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Configuration
    input wire logic [FSEL_WIDTH-1:0] pin_function_select_reg,
    input wire logic [PULLUP_WIDTH-1:0] port_c_pullup_reg,
    input wire pin_cfg_t index_cfg,
    input wire pin_cfg_t home_cfg,
    // Index pad
    input wire logic index_pad_i,
    output logic index_pad_o,
    output logic index_pad_oe,
    output logic index_pad_pu,
    // Home pad
    input wire logic home_pad_i,
    output logic home_pad_o,
    output logic home_pad_oe,
    output logic home_pad_pu,
    // Decoder 1
    output logic decoder1_index,
    output logic decoder1_home,
    // Timer B channels
    input wire timer_chan_t timer_b_channel_two_out,
    input wire timer_chan_t timer_b_channel_three_out,
    output logic timer_b_channel_two_in,
    output logic timer_b_channel_three_in,
    // SPI 1 core
    input wire logic spi1_master_mode,
    input wire logic spi1_slave_out_data,
    input wire logic spi1_master_in_en,
    output logic spi1_slave_out_in,
    output logic spi1_select_in,
    output logic spi1_slave_selected,
    output logic spi1_mode_fault,
    // Port C bits 2 and 3
    output logic port_c_bit2,
    output logic port_c_bit3,
    // Function status
    output pin_fn_t index_fn,
    output pin_fn_t home_fn
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release tracking

    logic run_r;
    logic run_nxt;

    // Functions wait one edge after release so pads never glitch out of reset
    always_comb begin
        run_nxt = 1'b1;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            run_r <= 1'b0;
        end else begin
            run_r <= run_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pad input synchronisers

    logic [1:0] pad_sync_q;

    pad_sync #(
        .WIDTH(2)
    ) u_pad_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .d({home_pad_i, index_pad_i}),
        .q(pad_sync_q)
    );

    logic index_in;
    logic home_in;
    assign index_in = pad_sync_q[0];
    assign home_in = pad_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Function selection

    logic index_spi_sel;
    logic home_spi_sel;
    logic idx_timer_sel;
    logic hom_timer_sel;
    logic idx_gpio_sel;
    logic hom_gpio_sel;

    // Reduced variant has no usable default; GPIO input stands in until set
    assign index_spi_sel = pin_function_select_reg[INDEX_SPI_SEL_BIT];
    assign home_spi_sel = pin_function_select_reg[HOME_SPI_SEL_BIT];
    assign idx_timer_sel = index_cfg.timer_sel;
    assign hom_timer_sel = home_cfg.timer_sel;
    assign idx_gpio_sel = index_cfg.gpio_sel | !FULL_VARIANT;
    assign hom_gpio_sel = home_cfg.gpio_sel | !FULL_VARIANT;

    pin_fn_t index_fn_c;
    pin_fn_t home_fn_c;

    pin_fn_decode u_index_dec (
        .spi_sel(index_spi_sel),
        .timer_sel(idx_timer_sel),
        .gpio_sel(idx_gpio_sel),
        .in_reset(!run_r),
        .fn(index_fn_c)
    );

    pin_fn_decode u_home_dec (
        .spi_sel(home_spi_sel),
        .timer_sel(hom_timer_sel),
        .gpio_sel(hom_gpio_sel),
        .in_reset(!run_r),
        .fn(home_fn_c)
    );

    assign index_fn = index_fn_c;
    assign home_fn = home_fn_c;

    ////////////////////////////////////////////////////////////////////////////
    // Registered pad drive and core inputs

    pad_drive_t index_pad_r;
    pad_drive_t index_pad_nxt;
    pad_drive_t home_pad_r;
    pad_drive_t home_pad_nxt;
    logic [5:0] core_r;
    logic [5:0] core_nxt;
    logic [1:0] gpio_r;
    logic [1:0] gpio_nxt;
    logic selected;
    logic mode_fault;

    // Select input is active low on the pin
    assign selected = run_r && (home_fn_c == FN_SPI) && !home_in && !spi1_master_mode;
    assign mode_fault = run_r && (home_fn_c == FN_SPI) && !home_in && spi1_master_mode;

    always_comb begin
        index_pad_nxt = '{o: 1'b0, oe: 1'b0, pu: 1'b1};
        home_pad_nxt = '{o: 1'b0, oe: 1'b0, pu: 1'b1};
        core_nxt = core_r;
        gpio_nxt = gpio_r;
        index_pad_nxt.pu = port_c_pullup_reg[INDEX_PULLUP_BIT];
        home_pad_nxt.pu = port_c_pullup_reg[HOME_PULLUP_BIT];
        unique case (index_fn_c)
            FN_DECODER: begin
                core_nxt[0] = index_in;
            end
            FN_TIMER: begin
                index_pad_nxt.o = timer_b_channel_two_out.o;
                index_pad_nxt.oe = timer_b_channel_two_out.oe;
                core_nxt[2] = index_in;
            end
            FN_SPI: begin
                // Pad register takes the core bit on the rising edge, giving a full-period lead
                index_pad_nxt.o = spi1_slave_out_data;
                index_pad_nxt.oe = selected && !spi1_master_mode;
                core_nxt[4] = spi1_master_mode && spi1_master_in_en ? index_in : 1'b0;
            end
            FN_GPIO: begin
                index_pad_nxt.o = index_cfg.gpio_out;
                index_pad_nxt.oe = index_cfg.gpio_dir_out;
                gpio_nxt[0] = index_cfg.gpio_dir_out ? index_cfg.gpio_out : index_in;
            end
        endcase
        unique case (home_fn_c)
            FN_DECODER: begin
                core_nxt[1] = home_in;
            end
            FN_TIMER: begin
                home_pad_nxt.o = timer_b_channel_three_out.o;
                home_pad_nxt.oe = timer_b_channel_three_out.oe;
                core_nxt[3] = home_in;
            end
            FN_SPI: begin
                // Select pin is input only
                core_nxt[5] = home_in;
            end
            FN_GPIO: begin
                home_pad_nxt.o = home_cfg.gpio_out;
                home_pad_nxt.oe = home_cfg.gpio_dir_out;
                gpio_nxt[1] = home_cfg.gpio_dir_out ? home_cfg.gpio_out : home_in;
            end
        endcase
        if (!run_r) begin
            index_pad_nxt = '{o: 1'b0, oe: 1'b0, pu: 1'b1};
            home_pad_nxt = '{o: 1'b0, oe: 1'b0, pu: 1'b1};
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            index_pad_r <= '{o: 1'b0, oe: 1'b0, pu: 1'b1};
            home_pad_r <= '{o: 1'b0, oe: 1'b0, pu: 1'b1};
            core_r <= 6'h20;
            gpio_r <= 2'h0;
        end else begin
            index_pad_r <= index_pad_nxt;
            home_pad_r <= home_pad_nxt;
            core_r <= core_nxt;
            gpio_r <= gpio_nxt;
        end
    end

    assign index_pad_o = index_pad_r.o;
    assign index_pad_oe = index_pad_r.oe;
    assign index_pad_pu = index_pad_r.pu;
    assign home_pad_o = home_pad_r.o;
    assign home_pad_oe = home_pad_r.oe;
    assign home_pad_pu = home_pad_r.pu;
    assign decoder1_index = core_r[0];
    assign decoder1_home = core_r[1];
    assign timer_b_channel_two_in = core_r[2];
    assign timer_b_channel_three_in = core_r[3];
    assign spi1_slave_out_in = core_r[4];
    assign spi1_select_in = core_r[5];
    assign spi1_slave_selected = selected;
    assign spi1_mode_fault = mode_fault;
    assign port_c_bit2 = gpio_r[0];
    assign port_c_bit3 = gpio_r[1];

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    chk_reset_pads_input: assert property (@(posedge mclk) disable iff (!arst_n)
        !run_r |=> !index_pad_oe && !home_pad_oe && index_pad_pu && home_pad_pu)
        else $error("pads not input with pull-up after reset");

    chk_slave_out_float: assert property (@(posedge mclk) disable iff (!arst_n)
        !selected |=> !(index_pad_oe && index_fn == FN_SPI && $past(index_fn) == FN_SPI))
        else $error("slave output driven while not selected");

    chk_slave_out_drive: assert property (@(posedge mclk) disable iff (!arst_n)
        selected && index_fn == FN_SPI |=> index_pad_oe && index_pad_o == $past(spi1_slave_out_data))
        else $error("selected slave does not drive data");

    chk_index_spi_gate: assert property (@(posedge mclk) disable iff (!arst_n)
        index_fn == FN_SPI |-> pin_function_select_reg[INDEX_SPI_SEL_BIT])
        else $error("index spi function without select bit");

    chk_home_spi_gate: assert property (@(posedge mclk) disable iff (!arst_n)
        home_fn == FN_SPI |-> pin_function_select_reg[HOME_SPI_SEL_BIT])
        else $error("home spi function without select bit");

    chk_index_pullup_bit: assert property (@(posedge mclk) disable iff (!arst_n)
        run_r && !port_c_pullup_reg[INDEX_PULLUP_BIT] |=> !index_pad_pu)
        else $error("index pull-up not disabled");

    chk_home_pullup_bit: assert property (@(posedge mclk) disable iff (!arst_n)
        run_r && !port_c_pullup_reg[HOME_PULLUP_BIT] |=> !home_pad_pu)
        else $error("home pull-up not disabled");

    // Synchroniser history only counts once it has run two edges past reset
    chk_decoder_index_path: assert property (@(posedge mclk) disable iff (!arst_n)
        index_fn == FN_DECODER && $past(run_r) |=> decoder1_index == $past(index_pad_i, 3))
        else $error("index pad not routed to decoder");

    chk_decoder_home_path: assert property (@(posedge mclk) disable iff (!arst_n)
        home_fn == FN_DECODER && $past(run_r) |=> decoder1_home == $past(home_pad_i, 3))
        else $error("home pad not routed to decoder");

    chk_timer_two_drive: assert property (@(posedge mclk) disable iff (!arst_n)
        index_fn == FN_TIMER |=> index_pad_oe == $past(timer_b_channel_two_out.oe))
        else $error("timer channel two not driving index pad");

    chk_timer_three_drive: assert property (@(posedge mclk) disable iff (!arst_n)
        home_fn == FN_TIMER |=> home_pad_oe == $past(timer_b_channel_three_out.oe))
        else $error("timer channel three not driving home pad");

    chk_gpio_dir_home: assert property (@(posedge mclk) disable iff (!arst_n)
        home_fn == FN_GPIO |=> home_pad_oe == $past(home_cfg.gpio_dir_out))
        else $error("home gpio direction wrong");

    cov_spi_slave_drive: cover property (@(posedge mclk) disable iff (!arst_n) selected ##1 index_pad_oe);
    cov_timer_index: cover property (@(posedge mclk) disable iff (!arst_n) index_fn == FN_TIMER);
    cov_gpio_out_home: cover property (@(posedge mclk) disable iff (!arst_n) home_fn == FN_GPIO && home_pad_oe);
    cov_mode_fault: cover property (@(posedge mclk) disable iff (!arst_n) mode_fault);

endmodule

//--- tb/pin_world.sv
// Outside world at the two shared pads: encoder, SPI peer and wire model
`timescale 1ns/1ns
module pin_world (
    // Clock
    input wire logic mclk,
    // Device pad drive
    input wire logic index_pad_o,
    input wire logic index_pad_oe,
    input wire logic index_pad_pu,
    input wire logic home_pad_o,
    input wire logic home_pad_oe,
    input wire logic home_pad_pu,
    // Outside drivers
    input wire logic ext_index_en,
    input wire logic ext_index_val,
    input wire logic ext_home_en,
    input wire logic ext_home_val,
    // Resolved pad levels
    output logic index_pad_i,
    output logic home_pad_i,
    output logic miso_seen_r
);
    logic idx_float_r = 1'b0;
    logic home_float_r = 1'b0;

    ////////////////////////////////////////////////////////////////
    // Undriven pad with no pull-up toggles, so a stale level never passes
    always @(posedge mclk) begin
        idx_float_r <= ~index_pad_i;
        home_float_r <= ~home_pad_i;
    end

    // Outside master pulls home low to select the device
    assign home_pad_i = home_pad_oe ? home_pad_o : ext_home_en ? ext_home_val :
        home_pad_pu ? 1'b1 : home_float_r;
    assign index_pad_i = index_pad_oe ? index_pad_o : ext_index_en ? ext_index_val :
        index_pad_pu ? 1'b1 : idx_float_r;

    // Master takes the slave bit on its clock edge
    always @(posedge mclk) begin
        miso_seen_r <= index_pad_i;
    end
endmodule

//--- tb/decoder1_index_home_pin_mux_bench.sv
// Self-checking bench for the decoder 1 index/home pin multiplexer
`timescale 1ns/1ns
module decoder1_index_home_pin_mux_bench;
    import pin_mux_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] fsel = 2'h0;
    logic [15:0] pur = 16'hffff;
    pin_cfg_t icfg = '0;
    pin_cfg_t hcfg = '0;
    timer_chan_t t2 = '0;
    timer_chan_t t3 = '0;
    logic master = 1'b0, sdata = 1'b0, men = 1'b0;
    logic xi_en = 1'b1, xi_v = 1'b1, xh_en = 1'b1, xh_v = 1'b1;
    logic ipo, ipoe, ipu, hpo, hpoe, hpu, ipi, hpi, dec_i, dec_h, t2in, t3in;
    logic smi, ssel, ssd, mf, pc2, pc3, miso_s;
    pin_fn_t ifn, hfn;
    int mismatches = 0;
    int total_checks = 0;
    int seed = 60;

    always #5 mclk = ~mclk;

    decoder1_index_home_pin_mux i_dut (.mclk(mclk), .arst_n(arst_n), .pin_function_select_reg(fsel),
        .port_c_pullup_reg(pur), .index_cfg(icfg), .home_cfg(hcfg), .index_pad_i(ipi), .index_pad_o(ipo),
        .index_pad_oe(ipoe), .index_pad_pu(ipu), .home_pad_i(hpi), .home_pad_o(hpo), .home_pad_oe(hpoe),
        .home_pad_pu(hpu), .decoder1_index(dec_i), .decoder1_home(dec_h), .timer_b_channel_two_out(t2),
        .timer_b_channel_three_out(t3), .timer_b_channel_two_in(t2in), .timer_b_channel_three_in(t3in),
        .spi1_master_mode(master), .spi1_slave_out_data(sdata), .spi1_master_in_en(men),
        .spi1_slave_out_in(smi), .spi1_select_in(ssel), .spi1_slave_selected(ssd), .spi1_mode_fault(mf),
        .port_c_bit2(pc2), .port_c_bit3(pc3), .index_fn(ifn), .home_fn(hfn));

    pin_world i_world (.mclk(mclk), .index_pad_o(ipo), .index_pad_oe(ipoe), .index_pad_pu(ipu),
        .home_pad_o(hpo), .home_pad_oe(hpoe), .home_pad_pu(hpu), .ext_index_en(xi_en),
        .ext_index_val(xi_v), .ext_home_en(xh_en), .ext_home_val(xh_v), .index_pad_i(ipi),
        .home_pad_i(hpi), .miso_seen_r(miso_s));

    ////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // SPI wins over timer, timer over GPIO
    function automatic pin_fn_t exp_fn(input logic spi, input logic tim, input logic gpio);
        return spi ? FN_SPI : tim ? FN_TIMER : gpio ? FN_GPIO : FN_DECODER;
    endfunction

    task automatic check_reset;
        check("index_pad_oe", ipoe, 1'b0);
        check("index_pad_pu", ipu, 1'b1);
        check("home_pad_oe", hpoe, 1'b0);
        check("home_pad_pu", hpu, 1'b1);
        check("spi1_select_in", ssel, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic settle_and_check;
        pin_fn_t fi, fh;
        logic ioe, io, hoe, ho, iw, hw, ik, hk, sel;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        fi = exp_fn(fsel[0], icfg.timer_sel, icfg.gpio_sel);
        fh = exp_fn(fsel[1], hcfg.timer_sel, hcfg.gpio_sel);
        hoe = fh == FN_TIMER ? t3.oe : fh == FN_GPIO ? hcfg.gpio_dir_out : 1'b0;
        ho = fh == FN_TIMER ? t3.o : hcfg.gpio_out;
        hk = hoe | xh_en | pur[3];
        hw = hoe ? ho : xh_en ? xh_v : 1'b1;
        sel = fh == FN_SPI && hk && !hw;
        ioe = fi == FN_SPI ? sel && !master : fi == FN_TIMER ? t2.oe : fi == FN_GPIO ? icfg.gpio_dir_out : 1'b0;
        io = fi == FN_SPI ? sdata : fi == FN_TIMER ? t2.o : icfg.gpio_out;
        ik = ioe | xi_en | pur[2];
        iw = ioe ? io : xi_en ? xi_v : 1'b1;
        check("index_fn", ifn, fi);
        check("home_fn", hfn, fh);
        check("index_pad_oe", ipoe, ioe);
        if (ioe) check("index_pad_o", ipo, io);
        check("home_pad_oe", hpoe, hoe);
        if (hoe) check("home_pad_o", hpo, ho);
        check("index_pad_pu", ipu, pur[2]);
        check("home_pad_pu", hpu, pur[3]);
        if (hk) check("spi1_slave_selected", ssd, sel && !master);
        if (hk) check("spi1_mode_fault", mf, fh == FN_SPI && !hw && master);
        if (hk && fh == FN_SPI) check("spi1_select_in", ssel, hw);
        if (ik && fi == FN_DECODER) check("decoder1_index", dec_i, iw);
        if (hk && fh == FN_DECODER) check("decoder1_home", dec_h, hw);
        if (ik && fi == FN_TIMER) check("timer_b_channel_two_in", t2in, iw);
        if (hk && fh == FN_TIMER) check("timer_b_channel_three_in", t3in, hw);
        if (ik && fi == FN_GPIO) check("port_c_bit2", pc2, iw);
        if (hk && fh == FN_GPIO) check("port_c_bit3", pc3, hw);
        if (ik && fi == FN_SPI && master && men) check("spi1_slave_out_in", smi, iw);
        if (ioe && fi == FN_SPI) check("miso_seen", miso_s, sdata);
    endtask

    // Hang guard
    initial begin
        repeat (60000) @(posedge mclk);
        mismatches++;
        report_and_stop;
    end

    initial begin
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        check_reset;
        check("index_fn", ifn, FN_DECODER);
        @(posedge mclk);
        arst_n <= 1'b1;
        settle_and_check;
        // Both pads released: pull-ups must hold them high
        @(posedge mclk);
        xi_en <= 1'b0;
        xh_en <= 1'b0;
        settle_and_check;
        // Selected SPI slave, data flipping on consecutive windows
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk);
            fsel <= 2'h3;
            xh_en <= 1'b1;
            xh_v <= 1'b0;
            sdata <= k[0];
            settle_and_check;
        end
        // Random mix; home kept driven so selection is always known
        for (int n = 0; n < 300; n++) begin
            @(posedge mclk);
            fsel <= 2'($random(seed));
            pur <= 16'($random(seed));
            icfg <= pin_cfg_t'(4'($random(seed)));
            hcfg <= pin_cfg_t'(4'($random(seed)));
            t2 <= timer_chan_t'(2'($random(seed)));
            t3 <= timer_chan_t'(2'($random(seed)));
            {master, sdata, men} <= 3'($random(seed));
            {xi_en, xi_v, xh_v} <= 3'($random(seed));
            xh_en <= 1'b1;
            settle_and_check;
            if (n == 150) begin
                // Reset in mid-run with a live configuration
                @(posedge mclk);
                arst_n <= 1'b0;
                repeat (2) @(posedge mclk);
                @(negedge mclk);
                check_reset;
                @(posedge mclk);
                arst_n <= 1'b1;
                settle_and_check;
            end
        end
        report_and_stop;
    end
endmodule
